// ===== shared/sprap_map.vh
// register map and protocol constants for the serial register access port
`ifndef SPRAP_MAP_VH
`define SPRAP_MAP_VH
`define SPRAP_CMD_WRITE     8'h61
`define SPRAP_CMD_READ      8'h41
`define SPRAP_WORD_BITS     6'h20
`define SPRAP_BIT_LAST      5'h1F
`define SPRAP_REGION_ID     16'h0000
`define SPRAP_REGION_CFG    16'h0800
`define SPRAP_REGION_CTRL   16'h1000
`define SPRAP_REGION_RAM    16'h8000
`define SPRAP_RAM_TOP       16'h87FF
`define SPRAP_RAM_OFS_MASK  16'h07FF
`define SPRAP_RAM_PREFIX    5'h00
`define SPRAP_RAM_PREFIX_HI 5'h10
`define SPRAP_REG_ID1       14'h0000
`define SPRAP_REG_ID2       14'h0001
`define SPRAP_REG_REV       14'h0002
`define SPRAP_REG_STATUS    14'h0003
`define SPRAP_STAT_FRAME    0
`define SPRAP_LEN_ZERO      8'h00
`define SPRAP_LEN_MAX       9'h100
`endif

// ===== rtl/sprap_fifo.v
// small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module sprap_fifo #(
  parameter WIDTH = 46,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            empty = (wr_ptr == rd_ptr);
  wire            full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                          (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  always @(posedge clk) begin
    if (in_valid && !full)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (out_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ===== rtl/sprap_port.v
// serial register access port: header decode, burst read and write
//
// What this block does
// - header word is command, address high, address low, length bytes
// - output stream opens with the summary status byte
// - write returns old contents, then stores new data
// - read returns current contents, leaves storage unchanged
// - input sampled on clock rise, output changes on clock fall
// - output floats while select is high; host keeps select low
// - fault bit drives out at select fall, held through first rise
// - write data commits only after 32 bits and then the next clock rise or select rise
// - bit count not multiple of 32 drops last word, sets flag
// - address regions: id, config, controller, message ram
// - address bits 1:0 ignored, whole word selected
// - command 0x61 writes length words to successive addresses
// - command 0x41 reads length words from successive addresses
// - length byte zero means 256 words
// - message ram holds 2K bytes
// - only lower 16 address bits are decoded
`timescale 1ns/1ns
`include "sprap_map.vh"
module sprap_port #(
  parameter RAM_WORDS = 512,
  parameter CFG_WORDS = 64,
  parameter CTL_WORDS = 64,
  parameter ID_WORD1  = 32'h1234ABCD, // arbitrary identity value
  parameter ID_WORD2  = 32'h00C0FFEE, // arbitrary identity value
  parameter REV_WORD  = 32'h00000001,
  parameter FIFO_DEPTH = 16
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        SCLK_PIN,
  input  wire        SELECT_N_PIN,
  input  wire        SERIAL_IN_PIN,
  output reg         SERIAL_OUT,
  output reg         SERIAL_OUT_OE_N,
  input  wire        FAULT_IN,
  input  wire [7:0]  STATUS_IN,
  output reg         FRAME_LENGTH_ERROR_FLAG,
  input  wire        ERROR_CLEAR,
  output wire        WRITE_VALID,
  input  wire        WRITE_READY,
  output wire [15:0] WRITE_ADDR,
  output wire [31:0] WRITE_DATA
);
  localparam ST_HDR  = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_DONE = 2'h2;

  // ==========================================================
  // pin synchronisers
  reg [2:0] sclk_s;
  reg [2:0] sel_s;
  reg [2:0] din_s;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_s <= 3'h0;
      sel_s  <= 3'h7;
      din_s  <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], SCLK_PIN};
      sel_s  <= {sel_s[1:0], SELECT_N_PIN};
      din_s  <= {din_s[1:0], SERIAL_IN_PIN};
    end
  end
  reg  sclk_q;
  reg  sel_q;
  wire sclk_lvl = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
  wire sel_lvl  = (sel_s[1] == sel_s[2]) ? sel_s[2] : sel_q;
  wire rise     = sclk_lvl && !sclk_q && !sel_q;
  wire fall     = !sclk_lvl && sclk_q && !sel_q;
  wire sel_fall = !sel_lvl && sel_q;
  wire sel_rise = sel_lvl && !sel_q;

  // ==========================================================
  // storage regions
  localparam RG_ID  = 2'h0;
  localparam RG_CFG = 2'h1;
  localparam RG_CTL = 2'h2;
  localparam RG_RAM = 2'h3;

  reg [31:0] ram  [0:RAM_WORDS-1];
  reg [31:0] cfg  [0:CFG_WORDS-1];
  reg [31:0] ctl  [0:CTL_WORDS-1];

  // shared by the read fetch and the commit path
  function [1:0] region;
    input [15:0] a;
    begin
      if (a >= `SPRAP_REGION_RAM && a <= `SPRAP_RAM_TOP)
        region = RG_RAM;
      else if (a >= `SPRAP_REGION_CTRL && a < `SPRAP_REGION_RAM)
        region = RG_CTL;
      else if (a >= `SPRAP_REGION_CFG && a < `SPRAP_REGION_CTRL)
        region = RG_CFG;
      else
        region = RG_ID;
    end
  endfunction

  function [15:0] norm_addr;
    input [15:0] a;
    begin
      // bare ram offset above the id words lands in message ram;
      // limitation: offsets that alias the id words cannot be reached
      if (a[15:11] == `SPRAP_RAM_PREFIX &&
          a[15:2] > `SPRAP_REG_STATUS)
        norm_addr = a | `SPRAP_REGION_RAM;
      else
        norm_addr = a;
      norm_addr[1:0] = 2'h0;
    end
  endfunction

  function [31:0] read_word;
    input [15:0] a;
    begin
      if (region(a) == RG_RAM)
        read_word = ram[a[10:2]];
      else if (region(a) == RG_CTL)
        read_word = ctl[a[7:2]];
      else if (region(a) == RG_CFG)
        read_word = cfg[a[7:2]];
      else if (a[15:2] == `SPRAP_REG_ID1)
        read_word = ID_WORD1;
      else if (a[15:2] == `SPRAP_REG_ID2)
        read_word = ID_WORD2;
      else if (a[15:2] == `SPRAP_REG_REV)
        read_word = REV_WORD;
      else if (a[15:2] == `SPRAP_REG_STATUS)
        read_word = {31'h0, FRAME_LENGTH_ERROR_FLAG};
      else
        read_word = 32'h0;
    end
  endfunction

  // ==========================================================
  // serial engine: shared state
  reg  [1:0]  state;
  reg  [4:0]  bit_cnt;
  reg  [7:0]  cmd;
  reg  [15:0] addr;
  reg  [8:0]  words_left;
  reg  [31:0] shift_in;
  reg  [31:0] shift_out;
  reg         word_pend;
  reg         push;
  reg  [15:0] push_addr;
  reg  [31:0] push_data;
  wire        fifo_ready;
  wire        last_bit = (bit_cnt == `SPRAP_BIT_LAST);
  wire [31:0] word_in  = {shift_in[30:0], din_s[2]};
  wire [31:0] rd_word  = read_word(addr);
  wire        is_write = (cmd == `SPRAP_CMD_WRITE);
  wire        is_read  = (cmd == `SPRAP_CMD_READ);
  wire        new_word = fall && (bit_cnt == 5'h0) &&
                         (state == ST_DATA) && (is_write || is_read);

  // ==========================================================
  // edge tracking of the synchronised pins
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_q <= 1'b0;
      sel_q  <= 1'b1;
    end else begin
      sclk_q <= sclk_lvl;
      sel_q  <= sel_lvl;
    end
  end

  // ==========================================================
  // frame state: header decode and word stepping
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state      <= ST_HDR;
      bit_cnt    <= 5'h0;
      cmd        <= 8'h0;
      addr       <= 16'h0;
      words_left <= 9'h0;
    end else if (sel_fall) begin
      state   <= ST_HDR;
      bit_cnt <= 5'h0;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 5'h1;
      if (last_bit && state == ST_HDR) begin
        cmd        <= word_in[31:24];
        addr       <= norm_addr(word_in[23:8]);
        words_left <= (word_in[7:0] == `SPRAP_LEN_ZERO) ?
                      `SPRAP_LEN_MAX :
                      {1'b0, word_in[7:0]};
        state      <= ST_DATA;
      end else if (last_bit && state == ST_DATA) begin
        addr       <= addr + 16'h4;
        words_left <= words_left - 9'h1;
        if (words_left == 9'h1)
          state <= ST_DONE;
      end
    end
  end

  // ==========================================================
  // input shifter
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      shift_in <= 32'h0;
    else if (rise)
      shift_in <= word_in;
  end

  // ==========================================================
  // output shifter and driver enable
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_out       <= 32'h0;
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b1;
    end else if (sel_fall) begin
      SERIAL_OUT_OE_N <= 1'b0;
      SERIAL_OUT      <= FAULT_IN;
      shift_out       <= {FAULT_IN, STATUS_IN[6:0], 24'h0};
    end else if (sel_rise) begin
      SERIAL_OUT_OE_N <= 1'b1;
    end else if (new_word) begin
      // fetched before the word's own write can land: old contents
      shift_out  <= rd_word;
      SERIAL_OUT <= rd_word[31];
    end else if (fall) begin
      SERIAL_OUT <= shift_out[30];
      shift_out  <= {shift_out[30:0], 1'b0};
    end
  end

  // ==========================================================
  // write capture: a word commits once it is known to be whole
  // limitation: a host that outruns the drain side loses words
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      word_pend <= 1'b0;
      push      <= 1'b0;
      push_addr <= 16'h0;
      push_data <= 32'h0;
    end else begin
      if (push && fifo_ready)
        push <= 1'b0;
      if (sel_fall) begin
        word_pend <= 1'b0;
      end else if (sel_rise) begin
        if (word_pend) begin
          push      <= 1'b1;
          word_pend <= 1'b0;
        end
      end else if (rise) begin
        if (word_pend && bit_cnt == 5'h0) begin
          push      <= 1'b1;
          word_pend <= 1'b0;
        end
        if (last_bit && state == ST_DATA && is_write) begin
          word_pend <= 1'b1;
          push_addr <= addr;
          push_data <= word_in;
        end
      end
    end
  end

  // ==========================================================
  // frame length error: set beats a clear in the same cycle
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      FRAME_LENGTH_ERROR_FLAG <= 1'b0;
    else if (sel_rise && bit_cnt != 5'h0)
      FRAME_LENGTH_ERROR_FLAG <= 1'b1;
    else if (ERROR_CLEAR)
      FRAME_LENGTH_ERROR_FLAG <= 1'b0;
  end

  // ==========================================================
  // commit path: buffered words land in storage in order
  wire        f_valid;
  wire [47:0] f_data;
  wire [15:0] f_addr = f_data[47:32];
  wire [1:0]  f_region = region(f_addr);
  assign WRITE_VALID = f_valid;
  assign WRITE_ADDR  = f_addr;
  assign WRITE_DATA  = f_data[31:0];
  sprap_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({push_addr, push_data}),
    .out_valid (f_valid),
    .out_ready (WRITE_READY),
    .out_data  (f_data)
  );
  // id words are read only, so writes there fall away
  always @(posedge CLK) begin
    if (f_valid && WRITE_READY) begin
      if (f_region == RG_RAM)
        ram[f_addr[10:2]] <= f_data[31:0];
      else if (f_region == RG_CTL)
        ctl[f_addr[7:2]] <= f_data[31:0];
      else if (f_region == RG_CFG)
        cfg[f_addr[7:2]] <= f_data[31:0];
    end
  end
endmodule

// ===== verification/sprap_port_chk.sv
// assertion checker bound to the serial register access port
`timescale 1ns/1ns
module sprap_port_chk (
  input logic        CLK,
  input logic        RST_N,
  input logic        SCLK_PIN,
  input logic        SELECT_N_PIN,
  input logic        SERIAL_OUT,
  input logic        SERIAL_OUT_OE_N,
  input logic        FAULT_IN,
  input logic        FRAME_LENGTH_ERROR_FLAG,
  input logic        ERROR_CLEAR,
  input logic        WRITE_VALID,
  input logic        WRITE_READY,
  input logic [15:0] WRITE_ADDR,
  input logic [31:0] WRITE_DATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // pins pass a 3-flop sync, so allow a few cycles of lag
  AST_OE_IDLE: assert property (SELECT_N_PIN [*7] |-> SERIAL_OUT_OE_N)
    else $error("output driven while deselected");
  AST_OE_ON: assert property (
    $fell(SELECT_N_PIN) |-> ##[1:6] !SERIAL_OUT_OE_N)
    else $error("output not enabled after select fall");
  AST_FAULT_FIRST: assert property (
    $fell(SELECT_N_PIN) |-> ##6 SERIAL_OUT == FAULT_IN)
    else $error("first output bit is not the fault bit");
  AST_OUT_HOLD: assert property (
    $rose(SCLK_PIN) && !SELECT_N_PIN |=> $stable(SERIAL_OUT) [*6])
    else $error("output moved after a clock rise");
  AST_WR_HOLD: assert property (
    WRITE_VALID && !WRITE_READY |=>
      WRITE_VALID && $stable(WRITE_ADDR) && $stable(WRITE_DATA))
    else $error("write stream dropped while stalled");
  AST_WR_ALIGN: assert property (
    WRITE_VALID |-> WRITE_ADDR[1:0] == 2'h0)
    else $error("write address not word aligned");
  AST_FLAG_HOLD: assert property (
    FRAME_LENGTH_ERROR_FLAG && !ERROR_CLEAR && !$past(ERROR_CLEAR) |=>
      FRAME_LENGTH_ERROR_FLAG)
    else $error("error flag lost without clear");
  AST_FLAG_CLR: assert property (
    ERROR_CLEAR && SELECT_N_PIN && $past(SELECT_N_PIN, 8) |->
      ##[1:2] !FRAME_LENGTH_ERROR_FLAG)
    else $error("error flag not cleared");
  AST_FLAG_CAUSE: assert property (
    $rose(FRAME_LENGTH_ERROR_FLAG) |-> SELECT_N_PIN)
    else $error("error flag set inside a frame");
endmodule

bind sprap_port sprap_port_chk sprap_port_chk_i (
  .CLK(CLK), .RST_N(RST_N), .SCLK_PIN(SCLK_PIN),
  .SELECT_N_PIN(SELECT_N_PIN), .SERIAL_OUT(SERIAL_OUT),
  .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .FAULT_IN(FAULT_IN),
  .FRAME_LENGTH_ERROR_FLAG(FRAME_LENGTH_ERROR_FLAG),
  .ERROR_CLEAR(ERROR_CLEAR), .WRITE_VALID(WRITE_VALID),
  .WRITE_READY(WRITE_READY), .WRITE_ADDR(WRITE_ADDR),
  .WRITE_DATA(WRITE_DATA));

// ===== verification/sprap_host.sv
// host-side serial master model for the register access port
`timescale 1ns/1ns
module sprap_host (
  output logic sclk,
  output logic sel_n,
  output logic serial_in_pin,
  input  logic serial_out_pin,
  input  logic sdo_oe_n
);
  logic [31:0] rxw [0:17];
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    serial_in_pin = 1'b1;
  end
  function automatic logic [31:0] word(input int k);
    return 32'h5A3C0000 ^ (k * 32'h01010111);
  endfunction
  // one frame: header, nw data words, then ex stray bits
  task automatic xfer(input logic [31:0] hdr, input int nw, input int ex);
    logic [31:0] tx;
    int          n;
    n = 32 * (nw + 1) + ex;
    #3 sel_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      tx = (i < 32) ? hdr : word(i / 32 - 1);
      serial_in_pin = tx[31 - i % 32];
      #80 sclk = 1'b1;
      // a floating output reads back inverted, never as a match
      rxw[i / 32] = {rxw[i / 32][30:0], sdo_oe_n ? ~serial_out_pin : serial_out_pin};
      #80 sclk = 1'b0;
    end
    #80 sel_n = 1'b1;
    serial_in_pin = 1'b1;
    #100;
  endtask
endmodule

// ===== verification/sprap_port_test.sv
// self-checking bench for the serial register access port
`timescale 1ns/1ns
module sprap_port_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fault = 1'b1;
  logic        err_clr = 1'b0;
  logic        wr_ready = 1'b0;
  logic [7:0]  status = 8'h2A;
  logic        sclk, sel_n, serial_in_pin, serial_out_pin, oe_n, flag, wr_valid;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  int          num_errors = 0;
  int          tests_run = 0;
  always #5 clk = ~clk;
  sprap_port sprap_port_i (
    .CLK(clk), .RST_N(rst_n), .SCLK_PIN(sclk), .SELECT_N_PIN(sel_n),
    .SERIAL_IN_PIN(serial_in_pin), .SERIAL_OUT(serial_out_pin), .SERIAL_OUT_OE_N(oe_n),
    .FAULT_IN(fault), .STATUS_IN(status),
    .FRAME_LENGTH_ERROR_FLAG(flag), .ERROR_CLEAR(err_clr),
    .WRITE_VALID(wr_valid), .WRITE_READY(wr_ready),
    .WRITE_ADDR(wr_addr), .WRITE_DATA(wr_data));
  sprap_host sprap_host_i (.sclk(sclk), .sel_n(sel_n), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .sdo_oe_n(oe_n));
  // ========
  // checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic frame(input logic [31:0] hdr, input int nw, input int ex);
    sprap_host_i.xfer(hdr, nw, ex);
    check({24'h0, sprap_host_i.rxw[0][31:24]},
          {24'h0, fault, status[6:0]});
  endtask
  // accept n stalled writes one at a time, checking each
  task automatic drain(input logic [15:0] a0, input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      @(negedge clk);
      while (wr_valid !== 1'b1 && t < 2000) begin
        @(negedge clk);
        t++;
      end
      if (t == 2000) begin
        check(32'h0, 32'h1);
        test_done;
      end
      check({16'h0, wr_addr}, {16'h0, a0 + 16'(4 * k)});
      check(wr_data, sprap_host_i.word(k));
      @(posedge clk) wr_ready <= 1'b1;
      @(posedge clk) wr_ready <= 1'b0;
    end
  endtask
  // ========
  // scenarios
  task automatic t_reset;
    #1 check({28'h0, serial_out_pin, oe_n, flag, wr_valid}, 32'h4);
  endtask
  task automatic t_burst;
    frame({8'h61, 16'h8636, 8'h02}, 2, 0);
    drain(16'h8634, 2);
    repeat (2) begin
      frame({8'h41, 16'h8634, 8'h02}, 2, 0);
      check(sprap_host_i.rxw[1], sprap_host_i.word(0));
      check(sprap_host_i.rxw[2], sprap_host_i.word(1));
    end
    check({31'h0, wr_valid}, 32'h0);
  endtask
  task automatic t_old;
    frame({8'h61, 16'h8638, 8'h01}, 1, 0);
    check(sprap_host_i.rxw[1], sprap_host_i.word(1));
    drain(16'h8638, 1);
    frame({8'h61, 16'h0640, 8'h01}, 1, 0);
    drain(16'h8640, 1);
    frame({8'h41, 16'h8640, 8'h01}, 1, 0);
    check(sprap_host_i.rxw[1], sprap_host_i.word(0));
  endtask
  task automatic t_fill;
    frame({8'h61, 16'h8000, 8'h10}, 16, 0);
    drain(16'h8000, 16);
    repeat (20) @(posedge clk);
    #1 check({31'h0, wr_valid}, 32'h0);
    frame({8'h41, 16'h8000, 8'h01}, 2, 0);
    check(sprap_host_i.rxw[2], 32'h0);
    frame({8'h41, 16'h8000, 8'h00}, 2, 0);
    check(sprap_host_i.rxw[2], sprap_host_i.word(1));
  endtask
  task automatic t_frame;
    @(posedge clk) fault <= 1'b0;
    frame({8'h41, 16'h0800, 8'h01}, 1, 8);
    check({31'h0, flag}, 32'h1);
    frame({8'h41, 16'h000C, 8'h01}, 1, 0);
    check({31'h0, sprap_host_i.rxw[1][0]}, 32'h1);
    @(posedge clk) err_clr <= 1'b1;
    @(posedge clk) err_clr <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({31'h0, flag}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_burst;
    t_old;
    t_fill;
    t_frame;
    test_done;
  end
endmodule
